// ### bench/acc_cpu_model.sv
// Purpose: Processor model that takes the comparator interrupt vector.
// Assumes: Shares the clock and reset of the comparator control block.
// Notes: The bench sets how long the processor waits before taking a vector.
`timescale 1ns/10ps
module acc_cpu_model (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_enable,
  input wire logic [3:0] i_delay,
  input wire logic i_irq_req,
  output logic o_vector_taken
);
  logic [3:0] wait_r;

  // A pending request is taken after the set delay; the pulse is never repeated
  // back to back, so a request that lingers for one cycle is not taken twice.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_r <= 4'h0;
      o_vector_taken <= 1'b0;
    end else begin
      o_vector_taken <= 1'b0;
      wait_r <= 4'h0;
      if (i_enable && i_irq_req && !o_vector_taken) begin
        wait_r <= wait_r + 4'h1;
        if (wait_r >= i_delay) begin
          o_vector_taken <= 1'b1;
          wait_r <= 4'h0;
        end
      end
    end
  end
endmodule

// ### bench/testbench.sv
// Purpose: Self-checking bench for the comparator control block.
// Assumes: Bus answers after the request is seen; outputs are sampled at the rising edge.
// Notes: Random pin levels and channels come from a fixed seed.
`timescale 1ns/10ps
`include "acc_consts.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module testbench;
  logic mclk = 0, arst_n = 0, rd = 0, wr = 0, comp = 0, pos = 0, neg = 0, gie = 0, conv = 0, cpu_en = 0;
  logic [3:0] addr = 0, dly = 0;
  logic [31:0] wdata = 0, rdata, r;
  logic [2:0] chan = 0, nch;
  logic wait_s, pwr, bg, nmux, pbo, nbo, prd, nrd, cap, irq, vec;
  logic [7:0] q;
  logic cap_ie = 0, cap_q = 0;
  int cap_hits = 0;
  int fail_count = 0, checked = 0, cycles = 0, seed = 32'h7d87;

  always #2.5 mclk = ~mclk;

  // Timer capture front end: counts rising capture inputs only while its interrupt is unmasked.
  always @(posedge mclk) begin
    cap_q <= cap;
    if (cap_ie && cap && !cap_q) cap_hits <= cap_hits + 1;
  end

  acc_ctrl dut_u (.i_mclk(mclk), .i_arst_n(arst_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_s),
    .i_comp_raw(comp), .i_pos_pin_raw(pos), .i_neg_pin_raw(neg), .i_global_irq_en(gie),
    .i_irq_vector_taken(vec), .i_converter_enable(conv), .i_channel_select(chan), .o_comp_power_off(pwr),
    .o_pos_bandgap_sel(bg), .o_neg_from_mux(nmux), .o_neg_channel(nch), .o_pos_buf_off(pbo),
    .o_neg_buf_off(nbo), .o_pos_pin_read(prd), .o_neg_pin_read(nrd), .o_capture_in(cap), .o_irq_req(irq));

  acc_cpu_model cpu_u (.i_mclk(mclk), .i_arst_n(arst_n), .i_enable(cpu_en), .i_delay(dly), .i_irq_req(irq),
    .o_vector_taken(vec));

  // ----------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------
  // Holds the request until waitrequest is seen low at a rising edge, then releases it.
  // Read data are taken at the same edge; one idle edge follows so the next call never re-drives in this step.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h0, d};
    do @(posedge mclk); while (wait_s !== 1'b0);
    q = rdata[7:0];
    `CHK("readdata_hi", 24'h0, rdata[31:8])
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] ex);
    bus(1'b0, a, 8'h00);
    `CHK("readback", ex, q)
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // The flag is set by any toggle, a falling edge or a rising edge; never by the reserved code.
  function automatic logic exp_flag(input logic [1:0] m, input logic e);
    return (m == 2'b00) || (m == 2'b11 && e) || (m == 2'b10 && !e);
  endfunction

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // A hang is cut short well past the expected length of the run.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(2);
    arst_n <= 1'b1;
    tick(3);
    rchk(`ACC_OFS_CTRL, 8'h00);
    rchk(`ACC_OFS_INDIS, 8'h00);
    rchk(`ACC_OFS_CONVB, 8'h00);
    rchk(4'hC, 8'h00);
    bus(1'b1, `ACC_OFS_CTRL, 8'hC4);
    `CHK("power_off", 1'b1, pwr)
    `CHK("bandgap", 1'b1, bg)
    rchk(`ACC_OFS_CTRL, 8'hC4);
    bus(1'b1, `ACC_OFS_CONVB, 8'hFF);
    rchk(`ACC_OFS_CONVB, 8'h40);
    // Random pin levels against random buffer-off bits; the upper bits are written as well.
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      pos <= r[8];
      neg <= r[9];
      bus(1'b1, `ACC_OFS_INDIS, r[7:0]);
      tick(4);
      `CHK("pos_pin", r[8] & ~r[0], prd)
      `CHK("neg_pin", r[9] & ~r[1], nrd)
      `CHK("buf_off", r[1:0], {nbo, pbo})
      rchk(`ACC_OFS_INDIS, {6'h00, r[1:0]});
    end
    // Every channel, with the converter off and on.
    for (int i = 0; i < 16; i++) begin
      chan <= i[2:0];
      conv <= i[3];
      tick(3);
      `CHK("neg_mux", !i[3], nmux)
      `CHK("neg_chan", i[3] ? 3'h0 : i[2:0], nch)
    end
    bus(1'b1, `ACC_OFS_CONVB, 8'h00);
    conv <= 1'b0;
    chan <= 3'($random(seed));
    tick(3);
    `CHK("neg_pin_route", 1'b0, nmux)
    `CHK("neg_chan_off", 3'h0, nch)
    bus(1'b1, `ACC_OFS_CTRL, 8'h00);
    `CHK("power_on", 1'b0, pwr)
    // Each event mode against a rising and a falling output, capture route on.
    for (int m = 0; m < 4; m++) begin
      for (int e = 0; e < 2; e++) begin
        comp <= !e[0];
        cap_ie <= e[0];
        tick(6);
        bus(1'b1, `ACC_OFS_CTRL, {4'b0001, 2'b01, m[1:0]});
        comp <= e[0];
        tick(6);
        `CHK("capture", e[0], cap)
        rchk(`ACC_OFS_CTRL, {2'b00, e[0], exp_flag(m[1:0], e[0]), 2'b01, m[1:0]});
        bus(1'b1, `ACC_OFS_CTRL, {4'b0000, 2'b01, m[1:0]});
        rchk(`ACC_OFS_CTRL, {2'b00, e[0], exp_flag(m[1:0], e[0]), 2'b01, m[1:0]});
      end
    end
    `CHK("capture_hits", 4, cap_hits)
    // Interrupt request against the global enable, the local enable and the vector take.
    comp <= 1'b0;
    cap_ie <= 1'b0;
    tick(6);
    bus(1'b1, `ACC_OFS_CTRL, 8'h13);
    bus(1'b1, `ACC_OFS_CTRL, 8'h0B);
    for (int g = 0; g < 2; g++) begin
      gie <= g[0];
      comp <= 1'b1;
      tick(6);
      `CHK("irq_gie", g[0], irq)
      `CHK("capture_off", 1'b0, cap)
      comp <= 1'b0;
      tick(6);
    end
    bus(1'b1, `ACC_OFS_CTRL, 8'h03);
    `CHK("irq_masked", 1'b0, irq)
    bus(1'b1, `ACC_OFS_CTRL, 8'h0B);
    `CHK("irq_again", 1'b1, irq)
    dly <= 4'($random(seed));
    cpu_en <= 1'b1;
    tick(25);
    `CHK("irq_taken", 1'b0, irq)
    rchk(`ACC_OFS_CTRL, 8'h0B);
    give_verdict();
  end
endmodule

// ### rtl/acc_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the comparator control block.
// Assumes: Avalon-MM byte addresses with one 32-bit word per register.
// Notes: Definitions only; included by its bare name.
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ACC_OFS_CTRL 4'h0
`define ACC_OFS_INDIS 4'h4
`define ACC_OFS_CONVB 4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACC_BIT_PWROFF 7
`define ACC_BIT_BGSEL 6
`define ACC_BIT_RESULT 5
`define ACC_BIT_FLAG 4
`define ACC_BIT_IE 3
`define ACC_BIT_CAPEN 2
`define ACC_BIT_MODE_HI 1
`define ACC_BIT_MODE_LO 0
`define ACC_BIT_NEG_OFF 1
`define ACC_BIT_POS_OFF 0
`define ACC_BIT_MUXEN 6

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define ACC_CTRL_RST 8'h00
`define ACC_INDIS_RST 8'h00
`define ACC_CONVB_RST 8'h00
`define ACC_SYNC_STAGES 2

// Synchroniser lanes.
`define ACC_SYN_COMP 0
`define ACC_SYN_POS 1
`define ACC_SYN_NEG 2
`define ACC_SYN_W 3

`endif

// ### rtl/acc_ctrl.sv
// Purpose: Register, event and routing control around an on-chip analog comparator.
// Assumes: Avalon-MM slave with waitrequest; comparator and pin inputs are asynchronous.
// Notes: Every access is answered one cycle after it is presented.
`timescale 1ns/10ps
`include "acc_consts.svh"

// Overview of operation
// [R1] Power-off bit removes comparator power.
// [R2] Software disables interrupt before toggling power.
// [R3] Bandgap select replaces positive pin input.
// [R4] Comparator result synchronised, one-two cycles late.
// [R5] Selected output event sets the flag.
// [R6] Interrupt requires flag, enable and global enable.
// [R7] Taking the vector clears the flag.
// [R8] Writing one clears flag; zero keeps it.
// [R9] Interrupt enable bit gates the request.
// [R10] Capture route feeds timer capture front end.
// [R11] Software also enables timer capture interrupt.
// [R12] Mode: toggle, reserved, falling, rising.
// [R13] Software disables interrupt before changing mode.
// [R14] Mux enable with converter off selects channel.
// [R15] Otherwise negative pin drives negative input.
// [R16] Disable bits blank pin reads, buffers off.
// [R17] Disable register upper bits read zero.
// [R18] Software disables unused analog pin buffers.
// [R19] Mux enable is converter control bit six.
// [R20] Events compare result with previous cycle.
module acc_ctrl #(
  parameter int ADDR_W = 4
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_comp_raw,
  input wire logic i_pos_pin_raw,
  input wire logic i_neg_pin_raw,
  input wire logic i_global_irq_en,
  input wire logic i_irq_vector_taken,
  input wire logic i_converter_enable,
  input wire logic [2:0] i_channel_select,
  output logic o_comp_power_off,
  output logic o_pos_bandgap_sel,
  output logic o_neg_from_mux,
  output logic [2:0] o_neg_channel,
  output logic o_pos_buf_off,
  output logic o_neg_buf_off,
  output logic o_pos_pin_read,
  output logic o_neg_pin_read,
  output logic o_capture_in,
  output logic o_irq_req
);
  import acc_pkg::*;

  // Address decoding needs the full register window.
  if (ADDR_W < 4) begin : g_chk
    $error("ADDR_W must be at least 4");
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  // Assertion is immediate, release is aligned to the clock.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  acc_sync_if sif ();

  assign sif.raw = {i_neg_pin_raw, i_pos_pin_raw, i_comp_raw};

  acc_sync u_sync (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n_r),
    .sif(sif)
  );

  logic res_sync;
  assign res_sync = sif.sync[`ACC_SYN_COMP]; // R4

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  acc_state_s st_r;
  acc_state_s st_nxt;
  logic req;
  logic take;
  logic wr_ctrl;
  logic wr_indis;
  logic wr_convb;
  logic rise;
  logic fall;
  logic event_det;
  logic [7:0] ctrl_view;
  logic [7:0] wbyte;

  // A request is taken on its second cycle; a read is captured on its first, so readdata stands from a flop.
  assign req = i_avs_read | i_avs_write;
  assign take = req & st_r.ack;
  assign wbyte = i_avs_writedata[7:0];
  assign wr_ctrl = take & i_avs_write & i_avs_byteenable[0] & (i_avs_address[3:0] == `ACC_OFS_CTRL);
  assign wr_indis = take & i_avs_write & i_avs_byteenable[0] & (i_avs_address[3:0] == `ACC_OFS_INDIS);
  assign wr_convb = take & i_avs_write & i_avs_byteenable[0] & (i_avs_address[3:0] == `ACC_OFS_CONVB);

  // Edges come from the synchronised result against its previous value.
  assign rise = res_sync & ~st_r.res_prev; // R20
  assign fall = ~res_sync & st_r.res_prev; // R20

  // The reserved mode never raises an event.
  always_comb begin
    case (st_r.mode)
      ACC_MODE_TOGGLE: event_det = rise | fall; // R12
      ACC_MODE_FALL: event_det = fall; // R12
      ACC_MODE_RISE: event_det = rise; // R12
      default: event_det = 1'b0; // R12
    endcase
  end

  // Current view of the control and status register.
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[`ACC_BIT_PWROFF] = st_r.pwr_off;
    ctrl_view[`ACC_BIT_BGSEL] = st_r.bg_sel;
    ctrl_view[`ACC_BIT_RESULT] = res_sync; // R4
    ctrl_view[`ACC_BIT_FLAG] = st_r.flag;
    ctrl_view[`ACC_BIT_IE] = st_r.ie;
    ctrl_view[`ACC_BIT_CAPEN] = st_r.cap_en;
    ctrl_view[`ACC_BIT_MODE_HI:`ACC_BIT_MODE_LO] = st_r.mode;
  end

  // Next state: bus slave, registers, flag and routing.
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = req & ~st_r.ack;
    st_nxt.res_prev = res_sync;
    if (i_avs_read & ~st_r.ack) begin
      case (i_avs_address[3:0])
        `ACC_OFS_CTRL: st_nxt.rdata = ctrl_view;
        `ACC_OFS_INDIS: st_nxt.rdata = {6'h00, st_r.dis_neg, st_r.dis_pos}; // R17
        `ACC_OFS_CONVB: st_nxt.rdata = {1'b0, st_r.mux_en, 6'h00};
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    if (wr_ctrl) begin
      st_nxt.pwr_off = wbyte[`ACC_BIT_PWROFF]; // R1
      st_nxt.bg_sel = wbyte[`ACC_BIT_BGSEL]; // R3
      st_nxt.ie = wbyte[`ACC_BIT_IE]; // R9
      st_nxt.cap_en = wbyte[`ACC_BIT_CAPEN]; // R10
      st_nxt.mode = acc_mode_e'(wbyte[`ACC_BIT_MODE_HI:`ACC_BIT_MODE_LO]); // R12
    end
    if (wr_indis) begin
      st_nxt.dis_neg = wbyte[`ACC_BIT_NEG_OFF]; // R16
      st_nxt.dis_pos = wbyte[`ACC_BIT_POS_OFF]; // R16
    end
    if (wr_convb) begin
      st_nxt.mux_en = wbyte[`ACC_BIT_MUXEN]; // R19
    end
    // Clear by write-one or vector; a new event in the same cycle wins.
    if ((wr_ctrl & wbyte[`ACC_BIT_FLAG]) | i_irq_vector_taken) begin
      st_nxt.flag = 1'b0; // R7 R8
    end
    if (event_det) begin
      st_nxt.flag = 1'b1; // R5 R20
    end
    // Routing outputs are registered so they never glitch.
    st_nxt.capture = st_r.cap_en & res_sync; // R10
    st_nxt.neg_mux = st_r.mux_en & ~i_converter_enable; // R14 R15
    st_nxt.neg_ch = (st_r.mux_en & ~i_converter_enable) ? i_channel_select : 3'h0; // R14
    st_nxt.pos_rd = ~st_r.dis_pos & sif.sync[`ACC_SYN_POS]; // R16
    st_nxt.neg_rd = ~st_r.dis_neg & sif.sync[`ACC_SYN_NEG]; // R16
  end

  // Every state bit resets to zero, matching the reset values in the constants header.
  always_ff @(posedge i_mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r <= '0;
      st_r.mode <= ACC_MODE_TOGGLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Waitrequest holds the first cycle of every access.
  assign o_avs_waitrequest = req & ~st_r.ack;
  assign o_avs_readdata = {24'h000000, st_r.rdata};
  assign o_comp_power_off = st_r.pwr_off; // R1
  assign o_pos_bandgap_sel = st_r.bg_sel; // R3
  assign o_neg_from_mux = st_r.neg_mux; // R15
  assign o_neg_channel = st_r.neg_ch;
  assign o_pos_buf_off = st_r.dis_pos; // R16
  assign o_neg_buf_off = st_r.dis_neg; // R16
  assign o_pos_pin_read = st_r.pos_rd;
  assign o_neg_pin_read = st_r.neg_rd;
  assign o_capture_in = st_r.capture;
  // The global enable is the processor's, so the request stays combinational on it.
  assign o_irq_req = st_r.flag & st_r.ie & i_global_irq_en; // R6 R9

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n_r);

  sequence s_raw_held;
    i_comp_raw [*3];
  endsequence

  sequence s_ctrl_write;
    wr_ctrl ##1 1'b1;
  endsequence

  a_power_follow: assert property (wr_ctrl |=> o_comp_power_off == $past(wbyte[7])) // R1
    else $error("power-off bit not applied");
  a_bandgap_follow: assert property (s_ctrl_write |-> o_pos_bandgap_sel == $past(wbyte[6])) // R3
    else $error("bandgap select not applied");
  a_result_sync: assert property (s_raw_held |-> ctrl_view[5]) // R4
    else $error("result not synchronised high");
  a_event_sets: assert property (event_det |=> st_r.flag) // R5 R20
    else $error("event did not set flag");
  a_irq_gated: assert property (o_irq_req |-> st_r.flag && st_r.ie && i_global_irq_en) // R6
    else $error("interrupt without all enables");
  a_vector_clear: assert property (i_irq_vector_taken && !event_det |=> !st_r.flag) // R7
    else $error("vector did not clear flag");
  a_w1c_flag: assert property (wr_ctrl && wbyte[4] && !event_det |=> !st_r.flag) // R8
    else $error("write one did not clear flag");
  a_w0_keeps: assert property (wr_ctrl && !wbyte[4] && st_r.flag |=> st_r.flag) // R8
    else $error("write zero changed flag");
  a_ie_blocks: assert property (!st_r.ie |-> !o_irq_req) // R9
    else $error("interrupt while disabled");
  a_capture_off: assert property (!st_r.cap_en |=> !o_capture_in) // R10
    else $error("capture driven while unrouted");
  a_mode_rsvd: assert property (st_r.mode == ACC_MODE_RSVD && !st_r.flag |=> !st_r.flag) // R12
    else $error("reserved mode set flag");
  a_neg_mux_sel: assert property (st_r.mux_en && !i_converter_enable // R14
    |=> o_neg_from_mux && o_neg_channel == $past(i_channel_select))
    else $error("mux channel not routed");
  a_neg_pin_sel: assert property (!st_r.mux_en || i_converter_enable |=> !o_neg_from_mux) // R15
    else $error("negative pin not selected");
  a_buf_off_read: assert property (o_pos_buf_off ##1 o_pos_buf_off |-> !o_pos_pin_read) // R16
    else $error("disabled pin read not zero");
  a_indis_rsvd: assert property (take && i_avs_read && i_avs_address[3:0] == `ACC_OFS_INDIS // R17
    |-> o_avs_readdata[7:2] == 6'h00)
    else $error("reserved bits read nonzero");
  a_convb_read: assert property (take && i_avs_read && i_avs_address[3:0] == `ACC_OFS_CONVB // R19
    |-> o_avs_readdata[6] == $past(st_r.mux_en))
    else $error("mux enable readback wrong");

  // The rise, fall and toggle set checks are built on the history of the synchronised result itself, not on the detector.
  sequence s_res_rise;
    !res_sync ##1 res_sync;
  endsequence

  sequence s_res_fall;
    res_sync ##1 !res_sync;
  endsequence

  a_rise_sets: assert property (s_res_rise ##0 (st_r.mode == ACC_MODE_RISE) |=> st_r.flag) // R12 R20
    else $error("rising edge did not set flag");
  a_fall_sets: assert property (s_res_fall ##0 (st_r.mode == ACC_MODE_FALL) |=> st_r.flag) // R12 R20
    else $error("falling edge did not set flag");
  a_toggle_sets: assert property (s_res_fall ##0 (st_r.mode == ACC_MODE_TOGGLE) |=> st_r.flag) // R12 R20
    else $error("toggle did not set flag");
  a_rise_only: assert property (st_r.mode == ACC_MODE_RISE && !rise && !st_r.flag |=> !st_r.flag) // R12
    else $error("rising mode set flag without rise");
  a_fall_only: assert property (st_r.mode == ACC_MODE_FALL && !fall && !st_r.flag |=> !st_r.flag) // R12
    else $error("falling mode set flag without fall");
  a_set_wins: assert property (event_det && i_irq_vector_taken |=> st_r.flag) // R5 R7
    else $error("clear beat a new event");
  a_irq_raise: assert property (st_r.flag && st_r.ie && i_global_irq_en |-> o_irq_req) // R6
    else $error("interrupt not requested");
  a_neg_buf_read: assert property (o_neg_buf_off ##1 o_neg_buf_off |-> !o_neg_pin_read) // R16
    else $error("disabled negative pin read not zero");
  a_capture_on: assert property (st_r.cap_en && res_sync |=> o_capture_in) // R10
    else $error("capture not driven from result");
  a_chan_zero: assert property (!st_r.mux_en || i_converter_enable // R15
    |=> o_neg_channel == 3'h0)
    else $error("channel not parked while unrouted");
  a_indis_keep: assert property (!wr_indis |=> $stable(o_pos_buf_off) && $stable(o_neg_buf_off)) // R16
    else $error("disable bits changed without write");
  a_mux_keep: assert property (!wr_convb |=> $stable(st_r.mux_en)) // R19
    else $error("mux enable changed without write");

endmodule

// ### rtl/acc_pkg.sv
// Purpose: Types shared by the comparator control block.
// Assumes: Constants come from acc_consts.svh.
// Notes: Holds types only.
`include "acc_consts.svh"
package acc_pkg;

  // Event mode select encodings.
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE = 2'b00,
    ACC_MODE_RSVD = 2'b01,
    ACC_MODE_FALL = 2'b10,
    ACC_MODE_RISE = 2'b11
  } acc_mode_e;

  // Whole state of the control block.
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic pwr_off;
    logic bg_sel;
    logic flag;
    logic ie;
    logic cap_en;
    acc_mode_e mode;
    logic dis_neg;
    logic dis_pos;
    logic mux_en;
    logic res_prev;
    logic capture;
    logic neg_mux;
    logic [2:0] neg_ch;
    logic pos_rd;
    logic neg_rd;
  } acc_state_s;

  // Whole state of the synchroniser.
  typedef struct packed {
    logic [`ACC_SYN_W-1:0] s1;
    logic [`ACC_SYN_W-1:0] s2;
  } acc_sync_s;

endpackage

// ### rtl/acc_sync.sv
// Purpose: Two-flop synchroniser for the comparator output and the two comparator pins.
// Assumes: Reset is already synchronous to i_mclk on release.
// Notes: The first stage is read only by the second.
`timescale 1ns/10ps
`include "acc_consts.svh"
module acc_sync (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  acc_sync_if.syn sif
);
  import acc_pkg::*;

  acc_sync_s st_r;
  acc_sync_s st_nxt;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // Each lane moves one stage per clock.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = sif.raw;
    st_nxt.s2 = st_r.s1;
  end

  // Metastability settles in s1 before anything downstream sees it.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sif.sync = st_r.s2;

endmodule

// ### rtl/acc_sync_if.sv
// Purpose: Carries raw and synchronised lanes between the control block and its synchroniser.
// Assumes: Lane order from acc_consts.svh.
// Notes: One lane per asynchronous input.
`timescale 1ns/10ps
`include "acc_consts.svh"
interface acc_sync_if;
  logic [`ACC_SYN_W-1:0] raw;
  logic [`ACC_SYN_W-1:0] sync;
  modport ctl (output raw, input sync);
  modport syn (input raw, output sync);
endinterface
